// File: inc/icr_pkg.sv
// Package: register map, field layout, reset values and operator codes
package icr_pkg;

  // Register byte offsets (one aligned 32-bit word each)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DEC_BASE = 8'h04;
  localparam logic [7:0] OFF_DMX_FIRST = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_DMX_LO = 8'h10;
  localparam logic [7:0] OFF_DMX_HI = 8'h14;

  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_WIN_MODE = 4;
  localparam int CTRL_RETAIN = 5;
  localparam int CTRL_CONN_LSB = 8;

  // Connection flags inside the control register, 1 = wired
  localparam int CONN_A = 0;
  localparam int CONN_B = 1;
  localparam int CONN_CMP_EN = 2;
  localparam int CONN_DEC_Q = 3;
  localparam int CONN_WIN_EN = 4;
  localparam int CONN_DMX_ADDR = 5;
  localparam int CONN_DMX_VAL = 6;
  localparam int CONN_W = 7;

  // Status register fields
  localparam int STAT_CMP = 0;
  localparam int STAT_WIN = 1;
  localparam int STAT_DEC_LSB = 8;
  localparam int STAT_WTB_LSB = 16;

  // Reset values
  localparam logic [2:0] CTRL_OP_RST = 3'h0;
  localparam logic CTRL_WIN_MODE_RST = 1'b0;
  localparam logic CTRL_RETAIN_RST = 1'b0;
  localparam logic [6:0] CTRL_CONN_RST = 7'h7f;
  localparam logic [14:0] DEC_BASE_RST = 15'h0000;
  localparam logic [15:0] DMX_FIRST_RST = 16'h0000;

  // Largest accepted decoder base value (32760)
  localparam logic [31:0] DEC_BASE_MAX = 32'h00007ff8;

  // Sizes
  localparam int DEC_OUTS = 8;
  localparam int DMX_OUTS = 4;

  // AHB-Lite codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Comparator operators
  typedef enum logic [2:0] {
    OP_GT, OP_GE, OP_EQ, OP_NE, OP_LE, OP_LT
  } icr_op_t;

endpackage

// File: hdl/icr_unit.sv
// Integer compare, decode, window, word/bit convert and demultiplex unit
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

module icr_unit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic signed [15:0] cmp_a,
  input wire logic signed [15:0] cmp_b,
  input wire logic cmp_en,
  output logic cmp_out,
  input wire logic signed [15:0] dec_val,
  input wire logic dec_q,
  output logic [7:0] dec_hit,
  input wire logic signed [15:0] win_val,
  input wire logic signed [15:0] win_lo,
  input wire logic signed [15:0] win_hi,
  input wire logic win_en,
  output logic win_out,
  input wire logic wtb_en,
  input wire logic [15:0] wtb_word,
  output logic [15:0] wtb_lines,
  input wire logic btw_en,
  input wire logic [15:0] btw_lines,
  output logic [15:0] btw_word,
  input wire logic dmx_q,
  input wire logic signed [15:0] dmx_addr,
  input wire logic [15:0] dmx_val,
  input wire logic prog_init,
  output logic [15:0] dmx_out0,
  output logic [15:0] dmx_out1,
  output logic [15:0] dmx_out2,
  output logic [15:0] dmx_out3
);

  // Whole module state, registered as one word
  typedef struct packed {
    logic [2:0] op;
    logic win_mode;
    logic retain;
    logic [6:0] conn;
    logic [14:0] dec_base;
    logic [15:0] dmx_first;
    logic cmp_out;
    logic win_out;
    logic [7:0] dec_hit;
    logic [15:0] wtb_lines;
    logic [15:0] btw_word;
    logic [3:0][15:0] dmx_out;
    logic dmx_q_prev;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } icr_state_t;

  icr_state_t st_r;
  icr_state_t st_nxt;

  logic signed [15:0] a_eff;
  logic signed [15:0] b_eff;
  logic cmp_en_eff;
  logic dec_q_eff;
  logic win_en_eff;
  logic signed [15:0] dmx_addr_eff;
  logic [15:0] dmx_val_eff;
  logic signed [16:0] dmx_off;
  logic dmx_in_range;
  logic dmx_rise;
  logic win_inside;
  logic [7:0] dec_match;
  logic bus_take;

  // Comparator evaluation for the selected operator
  function automatic logic cmp_eval(
    input logic [2:0] op,
    input logic signed [15:0] a,
    input logic signed [15:0] b
  );
    logic r;
    r = 1'b0;
    unique case (icr_pkg::icr_op_t'(op))
      icr_pkg::OP_GT: r = (a > b);
      icr_pkg::OP_GE: r = (a >= b);
      icr_pkg::OP_EQ: r = (a == b);
      icr_pkg::OP_NE: r = (a != b);
      icr_pkg::OP_LE: r = (a <= b);
      icr_pkg::OP_LT: r = (a < b);
      default: r = 1'b0; // Codes 6 and 7 never match
    endcase
    return r;
  endfunction

  // Read mux; unmapped offsets answer zero
  function automatic logic [31:0] rd_word(
    input icr_state_t s,
    input logic [7:0] addr
  );
    logic [31:0] w;
    w = 32'h00000000;
    case (addr)
      icr_pkg::OFF_CTRL: begin
        w[icr_pkg::CTRL_OP_LSB +: 3] = s.op;
        w[icr_pkg::CTRL_WIN_MODE] = s.win_mode;
        w[icr_pkg::CTRL_RETAIN] = s.retain;
        w[icr_pkg::CTRL_CONN_LSB +: icr_pkg::CONN_W] = s.conn;
      end
      icr_pkg::OFF_DEC_BASE: w[14:0] = s.dec_base;
      icr_pkg::OFF_DMX_FIRST: w[15:0] = s.dmx_first;
      icr_pkg::OFF_STATUS: begin
        w[icr_pkg::STAT_CMP] = s.cmp_out;
        w[icr_pkg::STAT_WIN] = s.win_out;
        w[icr_pkg::STAT_DEC_LSB +: 8] = s.dec_hit;
        w[icr_pkg::STAT_WTB_LSB +: 16] = s.wtb_lines;
      end
      icr_pkg::OFF_DMX_LO: w = {s.dmx_out[1], s.dmx_out[0]};
      icr_pkg::OFF_DMX_HI: w = {s.dmx_out[3], s.dmx_out[2]};
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  // Unwired inputs take their documented default values
  assign a_eff = st_r.conn[icr_pkg::CONN_A] ? cmp_a : 16'sh0000;
  assign b_eff = st_r.conn[icr_pkg::CONN_B] ? cmp_b : 16'sh0000;
  assign cmp_en_eff = cmp_en | ~st_r.conn[icr_pkg::CONN_CMP_EN];
  assign dec_q_eff = dec_q | ~st_r.conn[icr_pkg::CONN_DEC_Q];
  assign win_en_eff = win_en | ~st_r.conn[icr_pkg::CONN_WIN_EN];
  assign dmx_addr_eff = st_r.conn[icr_pkg::CONN_DMX_ADDR] ?
                        dmx_addr : 16'sh0000;
  assign dmx_val_eff = st_r.conn[icr_pkg::CONN_DMX_VAL] ?
                       dmx_val : 16'h0000;

  // Slot offset from first slot index, kept 17 bits so no wrap aliases
  assign dmx_off = {dmx_addr_eff[15], dmx_addr_eff} -
                   {st_r.dmx_first[15], st_r.dmx_first};
  assign dmx_in_range = (dmx_off[16:2] == 15'h0000);
  assign dmx_rise = dmx_q & ~st_r.dmx_q_prev;

  // Inclusive window; empty when the lower bound is above the upper
  assign win_inside = (win_val >= win_lo) && (win_val <= win_hi);

  // One equality comparator per decoder output
  genvar k;
  generate
    for (k = 0; k < icr_pkg::DEC_OUTS; k++) begin : g_dec
      logic [15:0] target;
      assign target = {1'b0, st_r.dec_base} + 16'(k);
      assign dec_match[k] = (dec_val == $signed(target));
    end
  endgenerate

  assign bus_take = hsel & hready & htrans[1];

  // Next-state logic for function units and register slave
  always_comb begin
    st_nxt = st_r;
    if (cmp_en_eff) begin
      st_nxt.cmp_out = cmp_eval(st_r.op, a_eff, b_eff);
    end
    if (dec_q_eff) begin
      st_nxt.dec_hit = dec_match;
    end
    if (win_en_eff) begin
      // Mode bit inverts the inside test
      st_nxt.win_out = win_inside ^ st_r.win_mode;
    end
    if (wtb_en) begin
      st_nxt.wtb_lines = wtb_word;
    end
    if (btw_en) begin
      st_nxt.btw_word = btw_lines;
    end
    st_nxt.dmx_q_prev = dmx_q;
    if (dmx_rise && dmx_in_range) begin
      st_nxt.dmx_out[dmx_off[1:0]] = dmx_val_eff;
    end
    // Program init wipes routed values unless retention is chosen
    if (prog_init && !st_r.retain) begin
      st_nxt.dmx_out = '0;
      st_nxt.dmx_q_prev = 1'b0;
    end
    // Write data phase
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        icr_pkg::OFF_CTRL: begin
          st_nxt.op = hwdata[icr_pkg::CTRL_OP_LSB +: 3];
          st_nxt.win_mode = hwdata[icr_pkg::CTRL_WIN_MODE];
          st_nxt.retain = hwdata[icr_pkg::CTRL_RETAIN];
          st_nxt.conn = hwdata[icr_pkg::CTRL_CONN_LSB +: icr_pkg::CONN_W];
        end
        icr_pkg::OFF_DEC_BASE: begin
          // Out-of-range base is dropped, old base stays
          if (hwdata <= icr_pkg::DEC_BASE_MAX) begin
            st_nxt.dec_base = hwdata[14:0];
          end
        end
        icr_pkg::OFF_DMX_FIRST: st_nxt.dmx_first = hwdata[15:0];
        default: st_nxt.wr_addr = st_r.wr_addr; // Read-only or unmapped
      endcase
    end
    // Address phase; only whole-word writes are stored
    st_nxt.wr_pend = bus_take & hwrite & (hsize == icr_pkg::HSIZE_WORD);
    st_nxt.wr_addr = haddr[7:0];
    // Read sees a write just before it, at the cost of next-cycle status
    if (bus_take && !hwrite) begin
      st_nxt.rdata = rd_word(st_nxt, haddr[7:0]);
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.op <= icr_pkg::CTRL_OP_RST;
      st_r.win_mode <= icr_pkg::CTRL_WIN_MODE_RST;
      st_r.retain <= icr_pkg::CTRL_RETAIN_RST;
      st_r.conn <= icr_pkg::CTRL_CONN_RST;
      st_r.dec_base <= icr_pkg::DEC_BASE_RST;
      st_r.dmx_first <= icr_pkg::DMX_FIRST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs, all from the state register except the constant hreadyout and hresp
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign cmp_out = st_r.cmp_out;
  assign dec_hit = st_r.dec_hit;
  assign win_out = st_r.win_out;
  assign wtb_lines = st_r.wtb_lines;
  assign btw_word = st_r.btw_word;
  assign dmx_out0 = st_r.dmx_out[0];
  assign dmx_out1 = st_r.dmx_out[1];
  assign dmx_out2 = st_r.dmx_out[2];
  assign dmx_out3 = st_r.dmx_out[3];

  // Checks on the function units
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  zero_operand_a: assert property (
    (!st_r.conn[icr_pkg::CONN_A] && !st_r.conn[icr_pkg::CONN_B] &&
     cmp_en_eff && st_r.op == 3'h2) |=> cmp_out)
    else $error("unwired operands not zero");

  cmp_true_a: assert property (
    (cmp_en_eff && st_r.op == 3'h5 && a_eff < b_eff) ##1 st_r.wr_pend == 1'b0
    |-> cmp_out)
    else $error("comparator less-than not set");

  cmp_hold_a: assert property (
    ($fell(cmp_en_eff)) |=> cmp_out == $past(cmp_out))
    else $error("comparator moved on enable fall");

  dec_hit_a: assert property (
    (dec_q_eff && dec_val == $signed({1'b0, st_r.dec_base} + 16'h0003) &&
     !st_r.wr_pend) |=> dec_hit == 8'h08)
    else $error("decoder hit wrong line");

  dec_inert_a: assert property (
    !dec_q_eff |=> $stable(dec_hit))
    else $error("decoder changed while not qualified");

  base_max_a: assert property (
    {17'h00000, st_r.dec_base} <= icr_pkg::DEC_BASE_MAX)
    else $error("decoder base above limit");

  win_swap_a: assert property (
    (win_en_eff && win_lo > win_hi && !st_r.wr_pend)
    |=> win_out == $past(st_r.win_mode))
    else $error("window with swapped bounds wrong");

  win_hold_a: assert property (
    !win_en_eff [*2] |-> $stable(win_out))
    else $error("window output moved while disabled");

  wtb_split_a: assert property (
    wtb_en |=> wtb_lines[0] == $past(wtb_word[0]) &&
               wtb_lines[15] == $past(wtb_word[15]))
    else $error("word split order wrong");

  btw_join_a: assert property (
    btw_en |=> btw_word == $past(btw_lines))
    else $error("bit join wrong");

  dmx_copy_a: assert property (
    (dmx_rise && dmx_in_range && dmx_off[1:0] == 2'h2 && !prog_init)
    |=> dmx_out2 == $past(dmx_val_eff) && $stable(dmx_out0))
    else $error("demux copy or keep wrong");

  dmx_range_a: assert property (
    (!(dmx_rise && dmx_in_range) && !prog_init)
    |=> $stable(dmx_out0) && $stable(dmx_out1) &&
        $stable(dmx_out2) && $stable(dmx_out3))
    else $error("demux output moved without a slot hit");

  dmx_init_a: assert property (
    (prog_init && !st_r.retain) |=> dmx_out1 == 16'h0000)
    else $error("demux not cleared on init");

endmodule // icr_unit

// File: tb/icr_peer.sv
// Upstream program logic model that raises the demux qualify line
`timescale 1ns/1ps

module icr_peer (
  input wire logic hclk,
  input wire logic fire,
  output logic q
);
  // Registered so qualify moves one scan after the request, like a real unit
  always_ff @(posedge hclk) begin
    q <= fire;
  end
endmodule // icr_peer

// File: tb/tb_top.sv
// Self-checking bench for the compare, decode and route unit
`timescale 1ns/1ps

module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, prog_init = 0, fire = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, cmp_out, win_out, dmx_q, r, last;
  logic cmp_en = 0, dec_q = 0, win_en = 0, wtb_en = 0, btw_en = 0;
  logic signed [15:0] cmp_a = 0, cmp_b = 0, dec_val = 0, dmx_addr = 0;
  logic signed [15:0] win_val = 0, win_lo = 0, win_hi = 0;
  logic signed [15:0] ra, rb, v, lo, hi, first;
  logic [15:0] wtb_word = 0, btw_lines = 0, dmx_val = 0, base, w;
  logic [15:0] wtb_lines, btw_word, o0, o1, o2, o3;
  logic [15:0] m[4] = '{default: 0};
  logic [7:0] dec_hit;
  logic [35:0] e;
  logic [35:0] exp_q[$];
  int fails = 0, samples_checked = 0;
  integer seed = 32'hc8b85d59;
  string names[11] = '{"cmp_out", "win_out", "dec_hit", "wtb_lines",
    "btw_word", "dmx_out0", "dmx_out1", "dmx_out2", "dmx_out3", "hrdata",
    "hresp"};

  always #2 hclk = ~hclk;

  icr_peer icr_peer_i (.hclk(hclk), .fire(fire), .q(dmx_q));

  icr_unit icr_unit_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cmp_a(cmp_a), .cmp_b(cmp_b),
    .cmp_en(cmp_en), .cmp_out(cmp_out), .dec_val(dec_val), .dec_q(dec_q),
    .dec_hit(dec_hit), .win_val(win_val), .win_lo(win_lo), .win_hi(win_hi),
    .win_en(win_en), .win_out(win_out), .wtb_en(wtb_en),
    .wtb_word(wtb_word), .wtb_lines(wtb_lines), .btw_en(btw_en),
    .btw_lines(btw_lines), .btw_word(btw_word), .dmx_q(dmx_q),
    .dmx_addr(dmx_addr), .dmx_val(dmx_val), .prog_init(prog_init),
    .dmx_out0(o0), .dmx_out1(o1), .dmx_out2(o2), .dmx_out3(o3));

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic want(input logic [3:0] c, input logic [31:0] x);
    exp_q.push_back({c, x});
  endtask

  task automatic check(input logic [3:0] c, input logic [31:0] x);
    logic [31:0] g;
    g = c == 0 ? 32'(cmp_out) : c == 1 ? 32'(win_out) : c == 2 ? 32'(dec_hit)
      : c == 3 ? 32'(wtb_lines) : c == 4 ? 32'(btw_word) : c == 5 ? 32'(o0)
      : c == 6 ? 32'(o1) : c == 7 ? 32'(o2) : c == 8 ? 32'(o3)
      : c == 9 ? hrdata : 32'(hresp);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", names[c], x, g);
    end
  endtask

  // Results settle by the falling edge, so notes are judged there
  always @(negedge hclk) begin
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(e[35:32], e[31:0]);
    end
  end

  // One single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    want(10, 32'h0); // Every answer must be OKAY
  endtask

  function automatic logic cref(input int op, input int a, input int b);
    case (op)
      0: return a > b;
      1: return a >= b;
      2: return a == b;
      3: return a != b;
      4: return a <= b;
      default: return a < b;
    endcase
  endfunction

  // Qualify pulse held n extra scans while the value pin keeps changing
  task automatic copy(input logic signed [15:0] a, input logic [15:0] d,
                      input int n, input logic nc);
    int i;
    dmx_addr <= nc ? ~a : a;
    dmx_val <= nc ? ~d : d;
    fire <= 1;
    repeat (2) @(posedge hclk);
    dmx_val <= d ^ 16'h5a5a;
    repeat (n) @(posedge hclk);
    fire <= 0;
    i = a - first;
    if (i >= 0 && i < 4)
      m[i] = d;
    for (int k = 0; k < 4; k++)
      want(4'(5 + k), 32'(m[k]));
    repeat (2) @(posedge hclk);
  endtask

  task automatic init_pulse();
    prog_init <= 1;
    @(posedge hclk);
    prog_init <= 0;
    for (int k = 0; k < 4; k++)
      want(4'(5 + k), 32'(m[k]));
  endtask

  // Watchdog well beyond the roughly 200 cycles the tests need
  initial begin
    #100000;
    fails++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    bus(0, icr_pkg::OFF_CTRL, 0);
    want(9, 32'h00007f00);
    cmp_en <= 1;
    for (int op = 0; op < 6; op++) begin
      bus(1, icr_pkg::OFF_CTRL, 32'h7f00 | op);
      for (int k = 0; k < 5; k++) begin
        ra = 16'($random(seed) % 3);
        rb = 16'($random(seed) % 3);
        cmp_a <= ra;
        cmp_b <= rb;
        @(posedge hclk);
        last = cref(op, ra, rb);
        want(0, 32'(last));
      end
    end
    cmp_en <= 0;
    cmp_a <= ra + 16'sh0007;
    @(posedge hclk);
    want(0, 32'(last));
    bus(1, icr_pkg::OFF_CTRL, 32'h7a05);
    cmp_a <= 16'sh0009;
    cmp_b <= 16'sh0001;
    @(posedge hclk);
    want(0, 32'h1);
    cmp_b <= -16'sh0001;
    @(posedge hclk);
    want(0, 32'h0);
    // Both operands unwired with equal: zero against zero is true
    bus(1, icr_pkg::OFF_CTRL, 32'h7c02);
    cmp_en <= 1;
    @(posedge hclk);
    want(0, 32'h1);
    $display("test comparator done");
    win_en <= 1;
    for (int md = 0; md < 2; md++) begin
      bus(1, icr_pkg::OFF_CTRL, 32'h7f00 | (md << 4));
      for (int k = 0; k < 12; k++) begin
        v = 16'($random(seed) % 5);
        lo = 16'($random(seed) % 5);
        hi = 16'($random(seed) % 5);
        win_val <= v;
        win_lo <= lo;
        win_hi <= hi;
        @(posedge hclk);
        r = lo <= hi && v >= lo && v <= hi;
        last = md ? !r : r;
        want(1, 32'(last));
      end
    end
    win_en <= 0;
    win_lo <= 16'sh7fff;
    @(posedge hclk);
    want(1, 32'(last));
    bus(1, icr_pkg::OFF_CTRL, 32'h6f10);
    // New wiring only acts from the edge after the write lands
    @(posedge hclk);
    want(1, 32'h1);
    $display("test window done");
    base = 16'(($random(seed) & 32'h7fff) % 32761);
    bus(1, icr_pkg::OFF_DEC_BASE, 32'(base));
    dec_q <= 1;
    for (int k = -1; k < 9; k++) begin
      dec_val <= 16'(base + k);
      @(posedge hclk);
      want(2, (k >= 0 && k < 8) ? 32'h1 << k : 32'h0);
    end
    dec_q <= 0;
    dec_val <= 16'(base + 3);
    @(posedge hclk);
    want(2, 32'h0);
    bus(1, icr_pkg::OFF_DEC_BASE, 32'd32761);
    bus(0, icr_pkg::OFF_DEC_BASE, 0);
    want(9, 32'(base));
    bus(1, icr_pkg::OFF_DEC_BASE, 32'd32760);
    bus(0, icr_pkg::OFF_DEC_BASE, 0);
    want(9, 32'd32760);
    bus(1, icr_pkg::OFF_CTRL, 32'h7700);
    dec_val <= 16'sh7ff9;
    @(posedge hclk);
    want(2, 32'h2);
    $display("test decoder done");
    wtb_en <= 1;
    btw_en <= 1;
    for (int k = 0; k < 5; k++) begin
      w = 16'($random(seed));
      wtb_word <= w;
      btw_lines <= ~w;
      @(posedge hclk);
      want(3, 32'(w));
      want(4, 32'(w ^ 16'hffff));
    end
    wtb_en <= 0;
    btw_en <= 0;
    wtb_word <= ~w;
    btw_lines <= w;
    @(posedge hclk);
    want(3, 32'(w));
    want(4, 32'(w ^ 16'hffff));
    // Status: lines w, decoder line 1, window and comparator both on
    bus(0, icr_pkg::OFF_STATUS, 0);
    want(9, {w, 16'h0203});
    $display("test converters done");
    bus(1, icr_pkg::OFF_CTRL, 32'h7f00);
    first = 16'($random(seed) % 100);
    bus(1, icr_pkg::OFF_DMX_FIRST, 32'(first));
    for (int s = -1; s < 5; s++)
      copy(16'(first + s), 16'($random(seed)), (s + 1) % 3, 0);
    bus(0, icr_pkg::OFF_DMX_LO, 0);
    want(9, {m[1], m[0]});
    bus(0, 8'h40, 0);
    want(9, 32'h0);
    m = '{default: 0};
    init_pulse();
    copy(16'(first + 2), 16'($random(seed)), 0, 0);
    bus(1, icr_pkg::OFF_CTRL, 32'h7f20);
    init_pulse();
    first = -16'sh0002;
    bus(1, icr_pkg::OFF_DMX_FIRST, 32'hfffffffe);
    bus(1, icr_pkg::OFF_CTRL, 32'h1f20);
    copy(16'sh0000, 16'h0000, 0, 1);
    $display("test demux done");
    @(negedge hclk);
    close_out();
  end
endmodule // tb_top
